// File: inc/nbsh_pkg.sv
// What this block does
// - Host read strobe goes straight to direction
// - I/O cycle, strobe high: store, write strobe
// - I/O cycle, strobe low: host ignores bus
// - No I/O: low strobe reads, high writes
package nbsh_pkg;
   localparam int DATA_W = 4; // Separator nibble width
   localparam int NCMD_W = 3; // I/O command select width
   localparam logic [NCMD_W-1:0] NO_CMD = 3'h0; // No I/O line active
   localparam logic [DATA_W-1:0] DATA_RST = 4'h0; // Data register reset value
   // Cycle phases; fetch and exec each end on an enable tick, done lasts one clock
   typedef enum logic [1:0] {NBSH_IDLE, NBSH_FETCH, NBSH_EXEC, NBSH_DONE} nbsh_state_e;
   // Request kinds from the user side
   typedef enum logic [1:0] {NBSH_MEM_RD, NBSH_MEM_WR, NBSH_IO_IN, NBSH_IO_OUT} nbsh_op_e;
   localparam int PHASE_DIV = 4; // System clocks per bus phase
endpackage

// File: testbench/nbsh_sep_model.sv
`timescale 1ns/10ps
// Behavioural four-bit separator, variant chosen by parameter
module nbsh_sep_model #(
   parameter bit IO_SIDE = 1'b0 // Memory side when low
) (
   input wire logic sel_in, // Unit select, high active
   input wire logic strobe_in, // Read strobe sets direction
   input wire logic [3:0] din_in, // Input side pins
   input wire logic [3:0] bus_in, // Resolved shared bus
   output logic [3:0] bus_drv_out, // Bus driver data
   output logic bus_oe_out, // Bus driver enable
   output logic [3:0] dout_out // Output side pins
);
   // Only one group enabled, and only when selected
   assign bus_oe_out = sel_in & (strobe_in == IO_SIDE);
   assign bus_drv_out = din_in;
   // Memory side holds outputs high, I/O side floats them
   assign dout_out = (sel_in & (strobe_in != IO_SIDE)) ? bus_in : (IO_SIDE ? 4'hZ : 4'hF);
endmodule // nbsh_sep_model

// File: testbench/tb.sv
`timescale 1ns/10ps
// Host with memory and I/O separators on one bus
module tb;
   logic sys_clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_ready, rsp_valid, mrs, mws, hoe, moe, ioe;
   logic [1:0] req_op = 2'h0; // Operation code
   logic [2:0] req_cmd = 3'h0, io_cmd; // I/O command lines
   logic [3:0] req_wdata = 4'h0, rdata, hdrv, mdrv, idrv, bus, mdout, idout, mem = 4'h0, io_got = 4'h0;
   logic [3:0] io_data = 4'h5; // I/O device input value
   int bad_count = 0, compares = 0;
   always #20 sys_clk = ~sys_clk;
   // Nothing driving: the pull-up wins
   assign bus = hoe ? hdrv : moe ? mdrv : ioe ? idrv : 4'hF;
   nbsh_host dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .req_valid_in(req_valid), .req_ready_out(req_ready),
      .req_op_in(req_op), .req_cmd_in(req_cmd), .req_wdata_in(req_wdata), .rsp_valid_out(rsp_valid),
      .rsp_rdata_out(rdata), .memory_read_strobe_out(mrs), .memory_write_strobe_out(mws), .io_cmd_out(io_cmd),
      .shared_bus_pins_in(bus), .shared_bus_pins_out(hdrv), .shared_bus_pins_oe_out(hoe));
   // Strobe wired straight to both directions
   nbsh_sep_model #(.IO_SIDE(1'b0)) msep (.sel_in(1'b1), .strobe_in(mrs), .din_in(mem), .bus_in(bus),
      .bus_drv_out(mdrv), .bus_oe_out(moe), .dout_out(mdout));
   nbsh_sep_model #(.IO_SIDE(1'b1)) isep (.sel_in(io_cmd != 3'h0), .strobe_in(mrs), .din_in(io_data),
      .bus_in(bus), .bus_drv_out(idrv), .bus_oe_out(ioe), .dout_out(idout));
   // Memory nibble and I/O device latch
   always @(posedge sys_clk) begin
      if (mws) mem <= mdout;
      if (io_cmd != 3'h0 && !mrs) io_got <= idout;
   end
   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask
   // One transfer, bounded waits for answer and idle
   task automatic do_op(input logic [1:0] op, input logic [2:0] cmd, input logic [3:0] wd);
      int n;
      n = 0;
      req_op = op; req_cmd = cmd; req_wdata = wd; req_valid = 1;
      @(posedge sys_clk);
      #1 req_valid = 0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({3'h0, rsp_valid}, 4'h1, "no answer");
      while (req_ready !== 1'b1 && n < 80) begin
         @(posedge sys_clk);
         #1 n++;
      end
      // A cycle that never ends counts as a mismatch
      chk({3'h0, req_ready}, 4'h1, "no return to idle");
   endtask
   task automatic t_mem;
      do_op(2'h1, 3'h0, 4'hA);
      chk(mem, 4'hA, "memory write");
      do_op(2'h0, 3'h0, 4'h0);
      chk(rdata, 4'hA, "memory read");
      $display("test mem done");
   endtask
   task automatic t_io_in;
      do_op(2'h2, 3'h2, 4'h0);
      chk(rdata, 4'h5, "io input to host");
      chk(mem, 4'h5, "io input to memory");
      $display("test io_in done");
   endtask
   task automatic t_io_out;
      do_op(2'h1, 3'h0, 4'hC);
      do_op(2'h3, 3'h1, 4'h0);
      chk(io_got, 4'hC, "memory to io");
      // Host must ignore the bus, so the last read value stays
      chk(rdata, 4'h5, "host took io out bus");
      chk({mrs, mws, 2'h0}, 4'h8, "idle strobes");
      chk({1'b0, io_cmd}, 4'h0, "idle command");
      $display("test io_out done");
   endtask
   task automatic give_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1;
      @(posedge sys_clk);
      #1 t_mem();
      t_io_in();
      t_io_out();
      give_verdict();
   end
   // Watchdog, far beyond the few dozen cycles needed
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
endmodule // tb

// File: verilog/nbsh_host.sv
`timescale 1ns/10ps
// Host sequencer driving a nibble bus separator pair
module nbsh_host (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [1:0] req_op_in,
   input wire logic [nbsh_pkg::NCMD_W-1:0] req_cmd_in,
   input wire logic [nbsh_pkg::DATA_W-1:0] req_wdata_in,
   output logic rsp_valid_out,
   output logic [nbsh_pkg::DATA_W-1:0] rsp_rdata_out,
   output logic memory_read_strobe_out,
   output logic memory_write_strobe_out,
   output logic [nbsh_pkg::NCMD_W-1:0] io_cmd_out,
   input wire logic [nbsh_pkg::DATA_W-1:0] shared_bus_pins_in,
   output logic [nbsh_pkg::DATA_W-1:0] shared_bus_pins_out,
   output logic shared_bus_pins_oe_out
);
   nbsh_pkg::nbsh_state_e state; // Cycle phase
   nbsh_pkg::nbsh_op_e op; // Latched request kind
   logic tick; // Phase enable
   logic [nbsh_pkg::DATA_W-1:0] bus_meta; // First sync stage
   logic [nbsh_pkg::DATA_W-1:0] bus_sync; // Second sync stage
   logic [nbsh_pkg::DATA_W-1:0] wdata; // Write nibble held for cycle
   logic host_reads; // Host samples the bus in this op

   nbsh_phase_div #(.DIV(nbsh_pkg::PHASE_DIV)) u_div (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .tick_out(tick)
   );

   // Bus pins come from outside, two flops first
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_meta <= nbsh_pkg::DATA_RST;
         bus_sync <= nbsh_pkg::DATA_RST;
      end else begin
         bus_meta <= shared_bus_pins_in;
         bus_sync <= bus_meta;
      end
   end

   // Requests accepted only in idle
   assign req_ready_out = (state == nbsh_pkg::NBSH_IDLE);
   // Memory reads and I/O in return data; I/O out ignores bus
   assign host_reads = (op == nbsh_pkg::NBSH_MEM_RD) || (op == nbsh_pkg::NBSH_IO_IN);

   // Phase sequencer
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= nbsh_pkg::NBSH_IDLE;
         op <= nbsh_pkg::NBSH_MEM_RD;
         wdata <= nbsh_pkg::DATA_RST;
      end else begin
         case (state)
            nbsh_pkg::NBSH_IDLE: begin
               if (req_valid_in) begin
                  state <= nbsh_pkg::NBSH_FETCH;
                  op <= nbsh_pkg::nbsh_op_e'(req_op_in);
                  wdata <= req_wdata_in;
               end
            end
            // Wait a phase tick so strobes settle before exec
            nbsh_pkg::NBSH_FETCH: if (tick) state <= nbsh_pkg::NBSH_EXEC;
            // Far side drives or latches during this phase
            nbsh_pkg::NBSH_EXEC: if (tick) state <= nbsh_pkg::NBSH_DONE;
            // One clock to put every line back at rest
            nbsh_pkg::NBSH_DONE: state <= nbsh_pkg::NBSH_IDLE;
            default: state <= nbsh_pkg::NBSH_IDLE;
         endcase
      end
   end

   // I/O command lines, held for the whole cycle
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         io_cmd_out <= nbsh_pkg::NO_CMD;
      end else if (state == nbsh_pkg::NBSH_IDLE && req_valid_in) begin
         // Memory ops keep all command lines low
         if (req_op_in[1]) begin
            io_cmd_out <= req_cmd_in;
         end else begin
            io_cmd_out <= nbsh_pkg::NO_CMD;
         end
      end else if (state == nbsh_pkg::NBSH_DONE) begin
         io_cmd_out <= nbsh_pkg::NO_CMD;
      end
   end

   // Read strobe: low for memory read and I/O out; wired straight to separators
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         memory_read_strobe_out <= 1'b1;
      end else if (state == nbsh_pkg::NBSH_IDLE && req_valid_in) begin
         memory_read_strobe_out <= !(req_op_in == 2'(nbsh_pkg::NBSH_MEM_RD) ||
            req_op_in == 2'(nbsh_pkg::NBSH_IO_OUT));
      end else if (state == nbsh_pkg::NBSH_DONE) begin
         memory_read_strobe_out <= 1'b1;
      end
   end

   // Write strobe late in cycle: memory write and I/O in
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         memory_write_strobe_out <= 1'b0;
      end else begin
         memory_write_strobe_out <= (state == nbsh_pkg::NBSH_EXEC) &&
            (op == nbsh_pkg::NBSH_MEM_WR || op == nbsh_pkg::NBSH_IO_IN);
      end
   end

   // Host drives bus only for its own memory write
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shared_bus_pins_oe_out <= 1'b0;
         shared_bus_pins_out <= nbsh_pkg::DATA_RST;
      end else begin
         shared_bus_pins_oe_out <= (state != nbsh_pkg::NBSH_IDLE) &&
            (state != nbsh_pkg::NBSH_DONE) && (op == nbsh_pkg::NBSH_MEM_WR);
         shared_bus_pins_out <= wdata;
      end
   end

   // Sample bus at end of exec phase
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rsp_valid_out <= 1'b0;
         rsp_rdata_out <= nbsh_pkg::DATA_RST;
      end else begin
         rsp_valid_out <= (state == nbsh_pkg::NBSH_EXEC) && tick;
         if (state == nbsh_pkg::NBSH_EXEC && tick && host_reads) begin
            rsp_rdata_out <= bus_sync;
         end
      end
   end

   // Write strobe comes only inside a cycle that stores
   property p_wr_strobe_op;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      memory_write_strobe_out |-> (op == nbsh_pkg::NBSH_MEM_WR || op == nbsh_pkg::NBSH_IO_IN);
   endproperty
   a_wr_strobe_op: assert property (p_wr_strobe_op) else $error("write strobe in wrong op");
   // I/O out keeps strobe low and never drives bus
   property p_io_out;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == nbsh_pkg::NBSH_EXEC && op == nbsh_pkg::NBSH_IO_OUT) |->
         (!memory_read_strobe_out && !shared_bus_pins_oe_out && !memory_write_strobe_out);
   endproperty
   a_io_out: assert property (p_io_out) else $error("io out cycle wrong");
   // Memory cycles carry no I/O command
   property p_mem_no_cmd;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == nbsh_pkg::NBSH_EXEC && !op[1]) |-> (io_cmd_out == nbsh_pkg::NO_CMD);
   endproperty
   a_mem_no_cmd: assert property (p_mem_no_cmd) else $error("command during memory cycle");
   // Host drives bus only while read strobe high
   property p_drive_strobe;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      shared_bus_pins_oe_out |-> memory_read_strobe_out;
   endproperty
   a_drive_strobe: assert property (p_drive_strobe) else $error("bus contention with read");
   // Accepted request answers in bounded time
   sequence s_accept;
      req_valid_in && req_ready_out;
   endsequence
   property p_answer;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_accept |-> ##[2:10] rsp_valid_out;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   // Per-op checks on what the separators will see
   // Idle host leaves every control line at rest
   property p_idle_quiet;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == nbsh_pkg::NBSH_IDLE) |->
         (memory_read_strobe_out && !memory_write_strobe_out && !shared_bus_pins_oe_out &&
         io_cmd_out == nbsh_pkg::NO_CMD);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("control lines active in idle");
   // Memory read: strobe low, bus left to memory
   property p_mem_read;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == nbsh_pkg::NBSH_EXEC && op == nbsh_pkg::NBSH_MEM_RD) |->
         (!memory_read_strobe_out && !shared_bus_pins_oe_out && !memory_write_strobe_out);
   endproperty
   a_mem_read: assert property (p_mem_read) else $error("memory read cycle wrong");
   // I/O in: strobe high, device owns the bus
   property p_io_in;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == nbsh_pkg::NBSH_EXEC && op == nbsh_pkg::NBSH_IO_IN) |->
         (memory_read_strobe_out && !shared_bus_pins_oe_out);
   endproperty
   a_io_in: assert property (p_io_in) else $error("io in cycle wrong");
   // Exec phase of a storing op
   sequence s_store_phase;
      state == nbsh_pkg::NBSH_EXEC && (op == nbsh_pkg::NBSH_MEM_WR || op == nbsh_pkg::NBSH_IO_IN);
   endsequence
   // Storing ops raise the write strobe one clock later
   property p_store_strobe;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_store_phase |=> memory_write_strobe_out;
   endproperty
   a_store_strobe: assert property (p_store_strobe) else $error("write strobe missing");
   // Last clock of the exec phase
   sequence s_exec_end;
      state == nbsh_pkg::NBSH_EXEC && tick;
   endsequence
   // Bus is sampled and answered as exec ends
   property p_sample_answer;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_exec_end |=> (rsp_valid_out && state == nbsh_pkg::NBSH_DONE);
   endproperty
   a_sample_answer: assert property (p_sample_answer) else $error("answer not at exec end");
   // Direction and command may not move mid-cycle
   property p_held;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == nbsh_pkg::NBSH_EXEC) |-> ($stable(memory_read_strobe_out) && $stable(io_cmd_out));
   endproperty
   a_held: assert property (p_held) else $error("strobe or command moved in cycle");
   // Host drives the bus only for its own write
   property p_oe_write_only;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      shared_bus_pins_oe_out |-> (op == nbsh_pkg::NBSH_MEM_WR);
   endproperty
   a_oe_write_only: assert property (p_oe_write_only) else $error("host drives bus outside write");
endmodule // nbsh_host

// File: verilog/nbsh_phase_div.sv
`timescale 1ns/10ps
// Divider that makes the slower bus phase rate
module nbsh_phase_div #(
   parameter int DIV = 4
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   output logic tick_out
);
   logic [7:0] count; // Phase counter
   // Wrap count and pulse once per wrap
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count <= 8'h00;
      end else if (count == 8'(DIV - 1)) begin
         count <= 8'h00;
      end else begin
         count <= count + 8'h01;
      end
   end
   assign tick_out = (count == 8'(DIV - 1));
endmodule // nbsh_phase_div
